// ===== logic/apf_pkg.sv
// Constants for the amplifier power and fault control register bank.
// Assumes an 8-bit register port decoded from the serial control port.
package apf_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets; page selector sits at offset zero on every page
  localparam logic [7:0] OFS_PAGE_SELECT   = 8'h00;
  localparam logic [7:0] OFS_RSVD_FIRST    = 8'h01;
  localparam logic [7:0] OFS_RSVD_LAST     = 8'h1D;
  localparam logic [7:0] OFS_FAULT_POLICY  = 8'h1E;
  localparam logic [7:0] OFS_HP_DRV_CTRL   = 8'h1F;
  localparam logic [7:0] OFS_SPK_DRV_CTRL  = 8'h20;

  // Page that holds this bank
  localparam logic [7:0] PAGE_AMP          = 8'h01;

  // Reset values
  localparam logic [7:0] RST_PAGE_SELECT   = 8'h00;
  localparam logic [7:0] RST_FAULT_POLICY  = 8'h00;
  localparam logic [7:0] RST_HP_DRV_CTRL   = 8'h04;
  localparam logic [7:0] RST_SPK_DRV_CTRL  = 8'h06;
  localparam logic [7:0] RDATA_IDLE        = 8'h00;

  // Fault policy fields
  localparam int unsigned FP_HP_KEEP       = 1;
  localparam int unsigned FP_SPK_KEEP      = 0;

  // Headphone driver control fields
  localparam int unsigned HP_LEFT_PWR      = 7;
  localparam int unsigned HP_RIGHT_PWR     = 6;
  localparam int unsigned HP_CM_MSB        = 4;
  localparam int unsigned HP_CM_LSB        = 3;
  localparam int unsigned HP_PROT_PWRDN    = 1;
  localparam int unsigned HP_SHORT_STAT    = 0;

  // Speaker driver control fields
  localparam int unsigned SPK_LEFT_PWR     = 7;
  localparam int unsigned SPK_RIGHT_PWR    = 6;
  localparam int unsigned SPK_SHORT_STAT   = 0;

endpackage

// ===== logic/apf_short_guard.sv
// Short-circuit power-off decision for headphone and speaker drivers.
// Assumes short detect levels synchronous to the system clock.
`timescale 1ns/1ps
module apf_short_guard (
  input  wire logic hp_short_det,
  input  wire logic spk_short_det,
  input  wire logic hp_keep_on_short,
  input  wire logic spk_keep_on_short,
  input  wire logic hp_prot_pwrdn,
  output logic      hp_pwr_clear,
  output logic      spk_pwr_clear
);

  always_comb begin
    // Headphone bits only drop when protection is in power-down mode
    hp_pwr_clear  = hp_short_det && !hp_keep_on_short
                    && hp_prot_pwrdn;
    spk_pwr_clear = spk_short_det && !spk_keep_on_short;
  end

endmodule

// ===== logic/apf_regs.sv
// Page selector and amplifier power / short-circuit control registers.
// Assumes a register port already decoded from the serial control port,
// and live short-detect levels from the analog drivers.
`timescale 1ns/1ps
module apf_regs
  import apf_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  input  wire logic                      reg_wr_en,
  input  wire logic                      reg_rd_en,
  input  wire logic [apf_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [apf_pkg::DATA_W-1:0] reg_wdata,
  output logic      [apf_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                      hp_short_det,
  input  wire logic                      spk_short_det,
  output logic      [apf_pkg::DATA_W-1:0] page_sel,
  output logic                           left_headphone_driver_pwr,
  output logic                           right_headphone_driver_pwr,
  output logic      [1:0]                hp_cm_sel,
  output logic                           hp_prot_pwrdn,
  output logic                           left_speaker_driver_pwr,
  output logic                           right_speaker_driver_pwr
);

  ////////////////////////////////////////////////////////////////////////

  logic [7:0] page_reg;
  logic [7:0] page_next;
  logic [7:0] policy_reg;
  logic [7:0] policy_next;
  logic [7:0] hp_reg;
  logic [7:0] hp_next;
  logic [7:0] spk_reg;
  logic [7:0] spk_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       hp_pwr_clear;
  logic       spk_pwr_clear;

  function automatic logic on_page_one(input logic [7:0] pg,
                                       input logic [7:0] adr,
                                       input logic [7:0] ofs);
    on_page_one = (pg == PAGE_AMP) && (adr == ofs);
  endfunction

  apf_short_guard u_guard (
    .hp_short_det      (hp_short_det),
    .spk_short_det     (spk_short_det),
    .hp_keep_on_short  (policy_reg[FP_HP_KEEP]),
    .spk_keep_on_short (policy_reg[FP_SPK_KEEP]),
    .hp_prot_pwrdn     (hp_reg[HP_PROT_PWRDN]),
    .hp_pwr_clear      (hp_pwr_clear),
    .spk_pwr_clear     (spk_pwr_clear)
  );

  ////////////////////////////////////////////////////////////////////////

  always_comb begin
    page_next   = page_reg;
    policy_next = policy_reg;
    hp_next     = hp_reg;
    spk_next    = spk_reg;
    if (reg_wr_en) begin
      if (reg_addr == OFS_PAGE_SELECT) begin
        page_next = reg_wdata;
      end
      // Reserved offsets 1-29 simply have no storage here
      if (on_page_one(page_reg, reg_addr, OFS_FAULT_POLICY)) begin
        policy_next = reg_wdata;
      end
      if (on_page_one(page_reg, reg_addr, OFS_HP_DRV_CTRL)) begin
        hp_next = reg_wdata;
      end
      if (on_page_one(page_reg, reg_addr, OFS_SPK_DRV_CTRL)) begin
        spk_next = reg_wdata;
      end
    end
    // Status bits are live, never stored
    hp_next[HP_SHORT_STAT]   = 1'b0;
    spk_next[SPK_SHORT_STAT] = 1'b0;
    // Protection wins over a same-cycle host write, so a shorted
    // driver cannot be re-enabled while its hp_pwr_clear or spk_pwr_clear holds
    if (hp_pwr_clear) begin
      hp_next[HP_LEFT_PWR]  = 1'b0;
      hp_next[HP_RIGHT_PWR] = 1'b0;
    end
    if (spk_pwr_clear) begin
      spk_next[SPK_LEFT_PWR]  = 1'b0;
      spk_next[SPK_RIGHT_PWR] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      page_reg   <= RST_PAGE_SELECT;
      policy_reg <= RST_FAULT_POLICY;
      hp_reg     <= RST_HP_DRV_CTRL;
      spk_reg    <= RST_SPK_DRV_CTRL;
    end else begin
      page_reg   <= page_next;
      policy_reg <= policy_next;
      hp_reg     <= hp_next;
      spk_reg    <= spk_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: data registered, valid the cycle after the read strobe

  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_en) begin
      rdata_next = RDATA_IDLE;
      if (reg_addr == OFS_PAGE_SELECT) begin
        rdata_next = page_reg;
      end else if (on_page_one(page_reg, reg_addr, OFS_FAULT_POLICY)) begin
        rdata_next = policy_reg;
      end else if (on_page_one(page_reg, reg_addr, OFS_HP_DRV_CTRL)) begin
        rdata_next = {hp_reg[7:1], hp_short_det};
      end else if (on_page_one(page_reg, reg_addr, OFS_SPK_DRV_CTRL)) begin
        // Live spk_short_det is read back whether or not a speaker driver is powered
        rdata_next = {spk_reg[7:1], spk_short_det};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_reg <= RDATA_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata                  = rdata_reg;
  assign page_sel                   = page_reg;
  assign left_headphone_driver_pwr  = hp_reg[HP_LEFT_PWR];
  assign right_headphone_driver_pwr = hp_reg[HP_RIGHT_PWR];
  assign hp_cm_sel                  = hp_reg[HP_CM_MSB:HP_CM_LSB];
  assign hp_prot_pwrdn              = hp_reg[HP_PROT_PWRDN];
  assign left_speaker_driver_pwr    = spk_reg[SPK_LEFT_PWR];
  assign right_speaker_driver_pwr   = spk_reg[SPK_RIGHT_PWR];

  ////////////////////////////////////////////////////////////////////////

  property p_page_write;
    @(posedge clk_sys) disable iff (sys_rst)
    reg_wr_en && reg_addr == OFS_PAGE_SELECT |=> page_sel == $past(reg_wdata);
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("page selector did not take written value");

  property p_hp_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    hp_short_det && !policy_reg[FP_HP_KEEP] && hp_prot_pwrdn
    |=> !left_headphone_driver_pwr && !right_headphone_driver_pwr;
  endproperty
  a_hp_clear: assert property (p_hp_clear)
    else $error("headphone power not cleared on short");

  property p_spk_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    spk_short_det && !policy_reg[FP_SPK_KEEP]
    |=> !left_speaker_driver_pwr && !right_speaker_driver_pwr;
  endproperty
  a_spk_clear: assert property (p_spk_clear)
    else $error("speaker power not cleared on short");

  property p_spk_keep;
    @(posedge clk_sys) disable iff (sys_rst)
    policy_reg[FP_SPK_KEEP] && !reg_wr_en
    |=> $stable(left_speaker_driver_pwr) && $stable(right_speaker_driver_pwr);
  endproperty
  a_spk_keep: assert property (p_spk_keep)
    else $error("speaker power changed while policy keeps it");

  property p_hp_left_write;
    @(posedge clk_sys) disable iff (sys_rst)
    reg_wr_en && page_sel == PAGE_AMP && reg_addr == OFS_HP_DRV_CTRL
    && !hp_short_det
    |=> left_headphone_driver_pwr == $past(reg_wdata[HP_LEFT_PWR])
        && hp_cm_sel == $past(reg_wdata[HP_CM_MSB:HP_CM_LSB]);
  endproperty
  a_hp_left_write: assert property (p_hp_left_write)
    else $error("headphone control write not applied");

  property p_hp_right_keep;
    @(posedge clk_sys) disable iff (sys_rst)
    !reg_wr_en && !hp_pwr_clear |=> $stable(right_headphone_driver_pwr);
  endproperty
  a_hp_right_keep: assert property (p_hp_right_keep)
    else $error("right headphone power changed without cause");

  property p_hp_status_read;
    @(posedge clk_sys) disable iff (sys_rst)
    reg_rd_en && page_sel == PAGE_AMP && reg_addr == OFS_HP_DRV_CTRL
    |=> reg_rdata[HP_SHORT_STAT] == $past(hp_short_det)
        && reg_rdata[HP_PROT_PWRDN] == $past(hp_prot_pwrdn);
  endproperty
  a_hp_status_read: assert property (p_hp_status_read)
    else $error("headphone status read wrong");

  property p_spk_read;
    @(posedge clk_sys) disable iff (sys_rst)
    reg_rd_en && page_sel == PAGE_AMP && reg_addr == OFS_SPK_DRV_CTRL
    |=> reg_rdata[SPK_SHORT_STAT] == $past(spk_short_det)
        && reg_rdata[SPK_LEFT_PWR] == $past(left_speaker_driver_pwr);
  endproperty
  a_spk_read: assert property (p_spk_read)
    else $error("speaker status read wrong");

  property p_clear_seen;
    @(posedge clk_sys) disable iff (sys_rst)
    spk_pwr_clear ##1 reg_rd_en && page_sel == PAGE_AMP
    && reg_addr == OFS_SPK_DRV_CTRL && !reg_wr_en
    |=> reg_rdata[SPK_LEFT_PWR] == 1'b0;
  endproperty
  a_clear_seen: assert property (p_clear_seen)
    else $error("protection power-off not visible on read");

  c_hp_trip:  cover property (@(posedge clk_sys) disable iff (sys_rst)
    left_headphone_driver_pwr ##1 hp_pwr_clear ##1
    !left_headphone_driver_pwr);
  c_spk_trip: cover property (@(posedge clk_sys) disable iff (sys_rst)
    right_speaker_driver_pwr ##1 spk_pwr_clear);
  c_page_two: cover property (@(posedge clk_sys) disable iff (sys_rst)
    reg_wr_en && reg_addr == OFS_PAGE_SELECT && reg_wdata == 8'h02);

endmodule

// ===== tb/apf_host_model.sv
// Host model: drives the decoded register port of the amplifier bank.
// Assumes clk_sys from the bench; changes its signals at falling edges.
`timescale 1ns/1ps
module apf_host_model
  import apf_pkg::*;
(
  input  wire logic                       clk_sys,
  output logic                            reg_wr_en,
  output logic                            reg_rd_en,
  output logic      [apf_pkg::ADDR_W-1:0] reg_addr,
  output logic      [apf_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic [apf_pkg::DATA_W-1:0] reg_rdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'hA5;
    reg_wdata = 8'h5A;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    // Reserved bits always carry their required pattern
    if (a == OFS_HP_DRV_CTRL) v = (v & 8'hDB) | 8'h04;
    if (a == OFS_SPK_DRV_CTRL) v = (v & 8'hC1) | 8'h06;
    // Reserved offsets are never written
    if (a >= OFS_RSVD_FIRST && a <= OFS_RSVD_LAST) return;
    @(negedge clk_sys);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = v;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    // Released lines show junk, not the last value
    reg_addr  = ~a;
    reg_wdata = ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_rd_en = 1'b1;
    reg_addr  = a;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    d = reg_rdata;
  endtask
endmodule

// ===== tb/amp_power_fault_control_regs_tb_top.sv
// Self-checking bench for the amplifier power and fault register bank.
// Assumes apf_regs and the host model; shorts driven at falling edges.
`timescale 1ns/1ps
module amp_power_fault_control_regs_tb_top;
  import apf_pkg::*;
  logic       clk_sys, sys_rst, reg_wr_en, reg_rd_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, page_sel;
  logic       hp_short_det, spk_short_det, hp_prot_pwrdn;
  logic       lhp, rhp, lspk, rspk;
  logic [1:0] hp_cm_sel;
  int         fails, checks;

  apf_host_model u_apf_host_model (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  apf_regs u_apf_regs (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .hp_short_det(hp_short_det), .spk_short_det(spk_short_det),
    .page_sel(page_sel), .left_headphone_driver_pwr(lhp),
    .right_headphone_driver_pwr(rhp), .hp_cm_sel(hp_cm_sel),
    .hp_prot_pwrdn(hp_prot_pwrdn), .left_speaker_driver_pwr(lspk),
    .right_speaker_driver_pwr(rspk));

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, string m);
    logic [7:0] d;
    u_apf_host_model.rd(a, d);
    chk(d, e, m);
  endtask

  // Short applied with given policy; power and live status checked
  task automatic short_case(input logic [7:0] pol, hpv, input logic hs, ss,
                            input logic [3:0] ep);
    u_apf_host_model.wr(OFS_FAULT_POLICY, pol);
    u_apf_host_model.wr(OFS_HP_DRV_CTRL, hpv);
    u_apf_host_model.wr(OFS_SPK_DRV_CTRL, 8'hC6);
    hp_short_det  = hs;
    spk_short_det = ss;
    @(negedge clk_sys);
    chk({4'h0, lhp, rhp, lspk, rspk}, {4'h0, ep}, "short pwr");
    rdchk(OFS_HP_DRV_CTRL, {ep[3:2], hpv[5:1], hs}, "hp live");
    rdchk(OFS_SPK_DRV_CTRL, {ep[1:0], 5'h03, ss}, "spk live");
    hp_short_det  = 1'b0;
    spk_short_det = 1'b0;
    $display("test short %h %h %b%b done", pol, hpv, hs, ss);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fails++;
    print_verdict();
  end

  initial begin
    fails = 0;
    checks = 0;
    hp_short_det = 1'b0;
    spk_short_det = 1'b0;
    sys_rst = 1'b1;
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk(page_sel, RST_PAGE_SELECT, "page rst");
    chk({4'h0, lhp, rhp, lspk, rspk}, 8'h00, "pwr rst");
    chk({5'h00, hp_cm_sel, hp_prot_pwrdn}, 8'h00, "hp rst");
    rdchk(OFS_HP_DRV_CTRL, 8'h00, "off page");
    u_apf_host_model.wr(OFS_PAGE_SELECT, PAGE_AMP);
    rdchk(OFS_PAGE_SELECT, PAGE_AMP, "page rb");
    rdchk(OFS_FAULT_POLICY, RST_FAULT_POLICY, "pol rst");
    rdchk(OFS_HP_DRV_CTRL, RST_HP_DRV_CTRL, "hp rst");
    rdchk(OFS_SPK_DRV_CTRL, RST_SPK_DRV_CTRL, "spk rst");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      u_apf_host_model.wr(OFS_HP_DRV_CTRL, 8'h87 | 8'(i << 3));
      chk({6'h00, hp_cm_sel}, 8'(i), "cm sel");
      chk({6'h00, lhp, rhp}, 8'h02, "hp left");
      rdchk(OFS_HP_DRV_CTRL, 8'h86 | 8'(i << 3), "hp rb");
    end
    u_apf_host_model.wr(OFS_HP_DRV_CTRL, 8'h40);
    chk({5'h00, lhp, rhp, hp_prot_pwrdn}, 8'h02, "hp right");
    u_apf_host_model.wr(OFS_SPK_DRV_CTRL, 8'h80);
    chk({6'h00, lspk, rspk}, 8'h02, "spk left");
    $display("test fields done");
    short_case(8'h00, 8'hC6, 1'b1, 1'b0, 4'b0011);
    short_case(8'h02, 8'hC6, 1'b1, 1'b0, 4'b1111);
    short_case(8'h00, 8'hC4, 1'b1, 1'b0, 4'b1111);
    short_case(8'h00, 8'hC6, 1'b0, 1'b1, 4'b1100);
    short_case(8'h01, 8'hC6, 1'b0, 1'b1, 4'b1111);
    short_case(8'h00, 8'hC6, 1'b1, 1'b1, 4'b0000);
    u_apf_host_model.wr(OFS_PAGE_SELECT, 8'hFF);
    rdchk(OFS_PAGE_SELECT, 8'hFF, "page ff");
    rdchk(OFS_FAULT_POLICY, 8'h00, "off page pol");
    u_apf_host_model.wr(OFS_HP_DRV_CTRL, 8'hC6);
    chk({6'h00, lhp, rhp}, 8'h00, "off page wr");
    $display("test pages done");
    // Mid-run reset must drop drivers that were powered up
    u_apf_host_model.wr(OFS_PAGE_SELECT, PAGE_AMP);
    u_apf_host_model.wr(OFS_HP_DRV_CTRL, 8'hDE);
    chk({6'h00, lhp, rhp}, 8'h03, "hp up");
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk(page_sel, RST_PAGE_SELECT, "page rst2");
    chk({lhp, rhp, hp_cm_sel, hp_prot_pwrdn, 3'h0}, 8'h00, "r2");
    $display("test mid reset done");
    print_verdict();
  end
endmodule
